// ==== src/tit_pkg.sv ====
// Functional notes
// - Slave PLL runs only with enable and oscillator.
// - PLL mode: outputs 3-0 input, 5-4 reference.
// - PLL drives clocks 5-4 and pulse 5 while enabled; pulse 4 stays high.
// - Loopback takes input timing from output two.
// - Position bit picks straddling or starting pulse.
// - Clock polarity bit picks boundary edge.
// - Frame pulse polarity bit picks active level.
package tit_pkg;
	// Register byte addresses
	localparam logic [7:0] TIT_MAIN_CONTROL_OFS = 8'h00;
	localparam logic [7:0] TIT_STATUS_OFS = 8'h04;
	// Main control fields
	localparam int TIT_RSVD_LSB = 14;
	localparam int TIT_SLV_PLL_BIT = 13;
	localparam int TIT_ROLE_LSB = 11;
	localparam int TIT_LOOP_BIT = 10;
	localparam int TIT_FP_POS_BIT = 9;
	localparam int TIT_CK_POL_BIT = 8;
	localparam int TIT_FP_POL_BIT = 7;
	localparam int TIT_RATE_LSB = 5;
	localparam logic [15:0] TIT_MAIN_CONTROL_RST = 16'h0000;
	// Only bits 15-5 live in this block
	localparam logic [15:0] TIT_CTRL_WMASK = 16'hffe0;
	// Role and rate codes
	localparam logic [1:0] TIT_ROLE_MASTER = 2'h0;
	localparam logic [1:0] TIT_RATE_16M = 2'h0;
	localparam logic [1:0] TIT_RATE_8M = 2'h1;
	localparam logic [1:0] TIT_RATE_4M = 2'h2;
	// Status fields
	localparam int TIT_STAT_PLL_BIT = 0;
	localparam int TIT_STAT_SLAVE_BIT = 1;
	localparam int TIT_STAT_FRAME_BIT = 2;
	localparam int TIT_STAT_WERR_BIT = 3;
	localparam int TIT_STAT_LEN_LSB = 16;
	localparam int TIT_LEN_W = 12;
	// Timing, system clock period in ps
	localparam int TIT_CLK_PS = 10000;
	localparam int TIT_FP_16M_NS = 61;
	localparam int TIT_FP_8M_NS = 122;
	localparam int TIT_FP_4M_NS = 244;
	localparam int TIT_HALF_16M_PS = 30518;
	localparam int TIT_HALF_8M_PS = 61035;
	localparam int TIT_HALF_4M_PS = 122070;
	localparam int TIT_BITS_16M = 2048;
	localparam int TIT_BITS_8M = 1024;
	localparam int TIT_BITS_4M = 512;
	// Longest accepted pulse: twice nominal, rounded down
	localparam int TIT_FP_16M_MAX = (2 * TIT_FP_16M_NS * 1000) / TIT_CLK_PS;
	localparam int TIT_FP_8M_MAX = (2 * TIT_FP_8M_NS * 1000) / TIT_CLK_PS;
	localparam int TIT_FP_4M_MAX = (2 * TIT_FP_4M_NS * 1000) / TIT_CLK_PS;
	// Half periods rounded down, never below one cycle
	localparam int TIT_HALF_16M_CYC = (TIT_HALF_16M_PS / TIT_CLK_PS) > 0 ?
		(TIT_HALF_16M_PS / TIT_CLK_PS) : 1;
	localparam int TIT_HALF_8M_CYC = TIT_HALF_8M_PS / TIT_CLK_PS;
	localparam int TIT_HALF_4M_CYC = TIT_HALF_4M_PS / TIT_CLK_PS;
endpackage

// ==== src/tit_timing_if.sv ====
`timescale 1ns/1ps
// Timing signals shared by the top, generator and frame detector
interface tit_timing_if;
	logic gen_ck; // Generated output clock
	logic gen_fp_n; // Generated frame pulse, active low
	logic frame_start; // One-cycle pulse at detected boundary
	logic width_err; // One-cycle pulse on overlong pulse
	logic [11:0] frame_len; // Input clocks in last frame
	modport gen (output gen_ck, output gen_fp_n);
	modport det (output frame_start, output width_err, output frame_len);
	modport top (input gen_ck, input gen_fp_n, input frame_start,
		input width_err, input frame_len);
endinterface

// ==== src/tit_timing_gen.sv ====
`timescale 1ns/1ps
// Master timing: divides the system clock to the selected rate
module tit_timing_gen (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic [1:0] rate_i,
	// Timing out
	tit_timing_if.gen tim
);
	logic [6:0] half_cnt; // Cycles in current half period
	logic [6:0] half_len; // Half period for selected rate
	logic [11:0] bit_cnt; // Clock periods into the frame
	logic [11:0] bit_last; // Last clock period of the frame
	logic ck; // Output clock level

	// Rate decode; code three falls back to the slowest rate
	always_comb begin
		case (rate_i)
			tit_pkg::TIT_RATE_16M: begin
				half_len = 7'(tit_pkg::TIT_HALF_16M_CYC);
				bit_last = 12'(tit_pkg::TIT_BITS_16M - 1);
			end
			tit_pkg::TIT_RATE_8M: begin
				half_len = 7'(tit_pkg::TIT_HALF_8M_CYC);
				bit_last = 12'(tit_pkg::TIT_BITS_8M - 1);
			end
			default: begin
				half_len = 7'(tit_pkg::TIT_HALF_4M_CYC);
				bit_last = 12'(tit_pkg::TIT_BITS_4M - 1);
			end
		endcase
	end

	// Half-period divider and clock toggle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_cnt <= 7'h00;
			ck <= 1'b0;
		end else if (half_cnt + 7'h01 >= half_len) begin
			half_cnt <= 7'h00;
			ck <= ~ck;
		end else begin
			half_cnt <= half_cnt + 7'h01;
		end
	end

	// Count clock periods; wraps at the frame length
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_cnt <= 12'h000;
		end else if (half_cnt + 7'h01 >= half_len && ck) begin
			bit_cnt <= (bit_cnt >= bit_last) ? 12'h000 : bit_cnt + 12'h001;
		end
	end

	// Frame pulse low through the first clock period of each frame
	assign tim.gen_ck = ck;
	assign tim.gen_fp_n = (bit_cnt != 12'h000);
endmodule

// ==== src/tit_frame_detect.sv ====
`timescale 1ns/1ps
// Finds frame boundaries in synchronised clock and frame pulse
module tit_frame_detect (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Synchronised timing levels
	input wire logic ck_i,
	input wire logic fp_i,
	// Control
	input wire logic ck_pol_i,
	input wire logic fp_pol_i,
	input wire logic fp_pos_i,
	input wire logic [5:0] fp_max_i,
	// Results
	tit_timing_if.det tim
);
	logic ck_q; // Clock level one cycle back
	logic prev_act; // Pulse state at the last opposite edge
	logic align_edge; // Edge that marks the boundary
	logic opp_edge; // The other edge
	logic fp_act; // Pulse in its active level
	logic [11:0] clk_cnt; // Boundary edges since frame start
	logic [5:0] w_cnt; // Cycles the pulse has been active
	logic start; // Boundary found this cycle

	assign fp_act = fp_pol_i ? fp_i : ~fp_i;
	// Polarity low: falling edge is the boundary edge
	assign align_edge = ck_pol_i ? (ck_i & ~ck_q) : (~ck_i & ck_q);
	assign opp_edge = ck_pol_i ? (~ck_i & ck_q) : (ck_i & ~ck_q);
	// Straddling pulse was already active half a clock earlier
	assign start = align_edge & fp_act &
		(fp_pos_i ? ~prev_act : prev_act);

	// Edge history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ck_q <= 1'b0;
			prev_act <= 1'b0;
		end else begin
			ck_q <= ck_i;
			if (opp_edge) begin
				prev_act <= fp_act;
			end
		end
	end

	// Frame length in input clocks, latched at each boundary
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_cnt <= 12'h000;
			tim.frame_len <= 12'h000;
			tim.frame_start <= 1'b0;
		end else begin
			tim.frame_start <= start;
			if (start) begin
				tim.frame_len <= clk_cnt;
				clk_cnt <= 12'h001;
			end else if (align_edge && clk_cnt != 12'hfff) begin
				clk_cnt <= clk_cnt + 12'h001;
			end
		end
	end

	// Pulse width watch; flags once when it outlasts the rate's limit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_cnt <= 6'h00;
			tim.width_err <= 1'b0;
		end else begin
			tim.width_err <= fp_act && w_cnt == fp_max_i;
			// Six bits so the slowest rate limit of 48 still fits
			if (!fp_act) begin
				w_cnt <= 6'h00;
			end else if (w_cnt != 6'h3f) begin
				w_cnt <= w_cnt + 6'h01;
			end
		end
	end
endmodule

// ==== src/tit_input_timing_control.sv ====
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Upper main control bits and the input timing they steer
module tit_input_timing_control (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// External timing pins
	input wire logic input_clock_pin_i,
	input wire logic input_frame_pulse_pin_i,
	input wire logic oscillator_enable_i,
	input wire logic [3:0] ref_i,
	input wire logic [1:0] ref_sel_i,
	// Timing outputs
	output logic [5:0] output_clock_pins_o,
	output logic [5:0] output_frame_pulse_pins_o,
	// Status outputs
	output logic pll_enable_o,
	output logic slave_mode_o,
	output logic frame_start_o
);
	tit_timing_if tim ();

	logic [15:0] main_control; // Bits 15-5 held, 4-0 read zero
	logic [1:0] ck_sync; // Input clock synchroniser
	logic [1:0] fp_sync; // Input frame pulse synchroniser
	logic [1:0] osc_sync; // Oscillator enable synchroniser
	logic [3:0] ref_s1; // Reference first stage
	logic [3:0] ref_s2; // Reference second stage
	logic [1:0] rsel_sync [2]; // Reference select synchroniser
	logic ref_q; // Selected reference one cycle back
	logic frame_seen; // Sticky boundary flag
	logic width_flag; // Sticky overlong pulse flag
	logic slave; // Slave role decoded
	logic pll_on; // PLL running
	logic loop_on; // Internal loopback in effect
	logic det_ck; // Clock seen by the detector
	logic det_fp; // Frame pulse seen by the detector
	logic [5:0] fp_max; // Pulse width limit for the rate
	logic ref_sel_lvl; // Selected reference level
	logic wb_req; // Valid bus cycle awaiting answer
	logic wr_ctrl; // Write to main control
	logic wr_stat; // Write to status
	logic [31:0] next_rdata; // Read mux result
	logic [15:0] wmask; // Byte lane mask for writes

	// Role from the two-bit field; any non-master code means slave
	assign slave = main_control[tit_pkg::TIT_ROLE_LSB +: 2] !=
		tit_pkg::TIT_ROLE_MASTER;
	// PLL needs slave role, its enable bit and the oscillator
	assign pll_on = slave && main_control[tit_pkg::TIT_SLV_PLL_BIT] &&
		osc_sync[1];
	// Loopback has no meaning once the device is a slave
	assign loop_on = !slave && main_control[tit_pkg::TIT_LOOP_BIT];

	// Pin synchronisers; first stages feed only second stages
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ck_sync <= 2'h0;
			fp_sync <= 2'h0;
			osc_sync <= 2'h0;
			ref_s1 <= 4'h0;
			ref_s2 <= 4'h0;
		end else begin
			ck_sync <= {ck_sync[0], input_clock_pin_i};
			fp_sync <= {fp_sync[0], input_frame_pulse_pin_i};
			osc_sync <= {osc_sync[0], oscillator_enable_i};
			ref_s1 <= ref_i;
			ref_s2 <= ref_s1;
		end
	end

	// Reference select synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsel_sync[0] <= 2'h0;
			rsel_sync[1] <= 2'h0;
		end else begin
			rsel_sync[0] <= ref_sel_i;
			rsel_sync[1] <= rsel_sync[0];
		end
	end

	// Detector source: pins, or output clock 2 and pulse 2 in loopback
	always_comb begin
		if (loop_on) begin
			det_ck = output_clock_pins_o[2];
			det_fp = output_frame_pulse_pins_o[2];
		end else begin
			det_ck = ck_sync[1];
			det_fp = fp_sync[1];
		end
	end

	// Loopback assumes tied pins and rate code 00; nothing is checked
	// here, the pins are simply not looked at while loopback holds.

	// Width limit tracks the selected rate
	always_comb begin
		case (main_control[tit_pkg::TIT_RATE_LSB +: 2])
			tit_pkg::TIT_RATE_16M: begin
				fp_max = 6'(tit_pkg::TIT_FP_16M_MAX);
			end
			tit_pkg::TIT_RATE_8M: begin
				fp_max = 6'(tit_pkg::TIT_FP_8M_MAX);
			end
			default: begin
				// Reserved code three treated as the slowest rate
				fp_max = 6'(tit_pkg::TIT_FP_4M_MAX);
			end
		endcase
	end

	// Boundary finder
	tit_frame_detect u_det (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ck_i(det_ck),
		.fp_i(det_fp),
		.ck_pol_i(main_control[tit_pkg::TIT_CK_POL_BIT]),
		.fp_pol_i(main_control[tit_pkg::TIT_FP_POL_BIT]),
		.fp_pos_i(main_control[tit_pkg::TIT_FP_POS_BIT]),
		.fp_max_i(fp_max),
		.tim(tim.det)
	);

	// Master divider, running at the selected rate
	tit_timing_gen u_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rate_i(main_control[tit_pkg::TIT_RATE_LSB +: 2]),
		.tim(tim.gen)
	);

	assign ref_sel_lvl = ref_s2[rsel_sync[1]];

	// Selected reference history for its edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_sel_lvl;
		end
	end

	// Output timing, registered; outputs 3-0 follow the chosen source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_clock_pins_o <= 6'h00;
			output_frame_pulse_pins_o <= 6'h3f;
		end else if (!slave) begin
			// Master: every output from the internal divider
			output_clock_pins_o <= {6{tim.gen_ck}};
			output_frame_pulse_pins_o <= {6{tim.gen_fp_n}};
		end else if (pll_on) begin
			// PLL generates clocks 5-4 and pulse 5; outputs 3-0 copy the input pins
			output_clock_pins_o[3:0] <= {4{ck_sync[1]}};
			output_frame_pulse_pins_o[3:0] <= {4{fp_sync[1]}};
			output_clock_pins_o[5:4] <= {2{ref_sel_lvl}};
			// Pulse 5 low for a cycle on each reference rise
			output_frame_pulse_pins_o[5:4] <=
				{~(ref_sel_lvl & ~ref_q), 1'b1};
		end else begin
			// PLL off: reference-locked outputs stand idle
			output_clock_pins_o[3:0] <= {4{ck_sync[1]}};
			output_frame_pulse_pins_o[3:0] <= {4{fp_sync[1]}};
			output_clock_pins_o[5:4] <= 2'h0;
			output_frame_pulse_pins_o[5:4] <= 2'h3;
		end
	end

	// Status outputs from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_enable_o <= 1'b0;
			slave_mode_o <= 1'b0;
			frame_start_o <= 1'b0;
		end else begin
			pll_enable_o <= pll_on;
			slave_mode_o <= slave;
			frame_start_o <= tim.frame_start;
		end
	end

	// Bus decode; answer comes one cycle after the request
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = wb_req && wb_we_i &&
		wb_adr_i == tit_pkg::TIT_MAIN_CONTROL_OFS;
	assign wr_stat = wb_req && wb_we_i && wb_adr_i == tit_pkg::TIT_STATUS_OFS;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} &
		tit_pkg::TIT_CTRL_WMASK;

	// Main control register; reserved 15-14 are stored as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_control <= tit_pkg::TIT_MAIN_CONTROL_RST;
		end else if (wr_ctrl) begin
			// Software keeps 15-14 at zero; only the read mux returns them
			main_control <= (main_control & ~wmask) |
				(wb_dat_i[15:0] & wmask);
		end
	end

	// Sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_seen <= 1'b0;
			width_flag <= 1'b0;
		end else begin
			if (tim.frame_start) begin
				frame_seen <= 1'b1;
			end else if (wr_stat && wb_sel_i[0] &&
				wb_dat_i[tit_pkg::TIT_STAT_FRAME_BIT]) begin
				frame_seen <= 1'b0;
			end
			if (tim.width_err) begin
				width_flag <= 1'b1;
			end else if (wr_stat && wb_sel_i[0] &&
				wb_dat_i[tit_pkg::TIT_STAT_WERR_BIT]) begin
				width_flag <= 1'b0;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			tit_pkg::TIT_MAIN_CONTROL_OFS: begin
				next_rdata[15:0] = main_control & tit_pkg::TIT_CTRL_WMASK;
			end
			tit_pkg::TIT_STATUS_OFS: begin
				next_rdata[tit_pkg::TIT_STAT_PLL_BIT] = pll_on;
				next_rdata[tit_pkg::TIT_STAT_SLAVE_BIT] = slave;
				next_rdata[tit_pkg::TIT_STAT_FRAME_BIT] = frame_seen;
				next_rdata[tit_pkg::TIT_STAT_WERR_BIT] = width_flag;
				next_rdata[tit_pkg::TIT_STAT_LEN_LSB +: tit_pkg::TIT_LEN_W] =
					tim.frame_len;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Acknowledge and read data; ack lasts exactly one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end
endmodule

// ==== testbench/tit_ts_src.sv ====
`timescale 1ns/1ps
// Backplane timing source, 125 ns clock, one pulse per N clocks
module tit_ts_src #(parameter int N = 8) (
	// Control
	input wire logic en_i,
	input wire logic ck_pol_i,
	input wire logic fp_pol_i,
	input wire logic fp_pos_i,
	input wire logic wide_i,
	// Timing pins
	output logic ck_o,
	output logic fp_o
);
	int k; // Half period index in the frame
	int w; // Pulse reach each side of the boundary, half periods
	initial begin
		ck_o = 1'b0;
		fp_o = 1'b1;
		k = 0;
		// Offset keeps pin edges clear of the system clock edges
		#3;
		forever begin
			#62.5;
			if (en_i) begin
				// Boundary edge at k zero
				ck_o = (k % 2 == 0) ? ck_pol_i : !ck_pol_i;
				// Straddling or starting pulse; wide doubles its length
				w = wide_i ? 2 : 1;
				if (fp_pos_i ? k < 2 * w :
					(k < w || k >= 2 * N - w)) begin
					fp_o = fp_pol_i;
				end else begin
					fp_o = !fp_pol_i;
				end
				k = (k + 1) % (2 * N);
			end else begin
				// Idle: clock stands, pulse inactive
				fp_o = !fp_pol_i;
			end
		end
	end
endmodule

// ==== testbench/tit_itc_asserts.sv ====
`timescale 1ns/1ps
// Port checks of the input timing control block
module tit_itc_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pins
	input wire logic input_clock_pin_i,
	input wire logic input_frame_pulse_pin_i,
	input wire logic oscillator_enable_i,
	input wire logic [3:0] ref_i,
	input wire logic [1:0] ref_sel_i,
	input wire logic [5:0] output_clock_pins_o,
	input wire logic [5:0] output_frame_pulse_pins_o,
	input wire logic pll_enable_o,
	input wire logic slave_mode_o,
	input wire logic frame_start_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic role_wr; // A role write was taken
	logic role_exp; // Slave role expected
	// Track the role field of the last control write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			role_wr <= 1'b0;
			role_exp <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
			wb_sel_i[1] && wb_adr_i == tit_pkg::TIT_MAIN_CONTROL_OFS) begin
			role_wr <= 1'b1;
			role_exp <= wb_dat_i[tit_pkg::TIT_ROLE_LSB +: 2] !=
				tit_pkg::TIT_ROLE_MASTER;
		end
	end
	AST_ACK_ONE:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_DROP:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	AST_ROLE:
		assert property (wb_ack_o && role_wr |-> ##[0:2]
			slave_mode_o == role_exp) else $error("role wrong");
	AST_PLL_SLAVE:
		assert property (!slave_mode_o [*2] |-> !pll_enable_o)
		else $error("pll in master");
	AST_PLL_OSC:
		assert property (!oscillator_enable_i [*5] |-> !pll_enable_o)
		else $error("pll without osc");
	AST_REF_OFF:
		assert property ((slave_mode_o && !pll_enable_o) [*2] |->
			output_clock_pins_o[5:4] == 2'h0) else $error("ref clk on");
	AST_CK_COPY:
		assert property ((pll_enable_o && $stable(input_clock_pin_i)) [*5]
			|-> output_clock_pins_o[3:0] == {4{input_clock_pin_i}})
		else $error("clock copy");
	AST_REF_COPY:
		assert property ((pll_enable_o && $stable(ref_i) &&
			$stable(ref_sel_i)) [*5] |-> output_clock_pins_o[5:4] ==
			{2{ref_i[ref_sel_i]}}) else $error("ref copy");
	AST_FS_PULSE:
		assert property (frame_start_o |=> !frame_start_o)
		else $error("frame start long");
endmodule
bind tit_input_timing_control tit_itc_asserts u_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .input_clock_pin_i(input_clock_pin_i),
	.input_frame_pulse_pin_i(input_frame_pulse_pin_i),
	.oscillator_enable_i(oscillator_enable_i), .ref_i(ref_i),
	.ref_sel_i(ref_sel_i), .output_clock_pins_o(output_clock_pins_o),
	.output_frame_pulse_pins_o(output_frame_pulse_pins_o),
	.pll_enable_o(pll_enable_o), .slave_mode_o(slave_mode_o),
	.frame_start_o(frame_start_o)
);

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// Self-checking bench of the input timing control block
module tb;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i, ref_i;
	logic [1:0] ref_sel_i;
	logic osc, src_en, s_ckp, s_fpp, s_pos, ck_pin, fp_pin, pll, slv, fs;
	logic s_wide;
	logic [5:0] ck_o, fp_o;
	int n_errors = 0;
	int samples_checked = 0;
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	tit_input_timing_control dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.input_clock_pin_i(ck_pin), .input_frame_pulse_pin_i(fp_pin),
		.oscillator_enable_i(osc), .ref_i(ref_i), .ref_sel_i(ref_sel_i),
		.output_clock_pins_o(ck_o), .output_frame_pulse_pins_o(fp_o),
		.pll_enable_o(pll), .slave_mode_o(slv), .frame_start_o(fs));
	tit_ts_src #(.N(8)) src (.en_i(src_en), .ck_pol_i(s_ckp),
		.fp_pol_i(s_fpp), .fp_pos_i(s_pos), .wide_i(s_wide), .ck_o(ck_pin),
		.fp_o(fp_pin));
	// Compare and count
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One classic cycle; read data lands in rd
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (i >= 20) begin
			n_errors++;
			give_verdict();
		end
	endtask
	// Control word; reserved top bits always zero
	function automatic logic [31:0] ctl(input logic [8:0] f);
		return {16'h0, 2'b00, f, 5'h0};
	endfunction
	// Reset values, lanes, unmapped place
	task automatic t_regs();
		bus(1'b0, 8'h00, 32'h0, 4'hf);
		check("ctrl rst", rd, {16'h0, tit_pkg::TIT_MAIN_CONTROL_RST});
		bus(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
		bus(1'b0, 8'h00, 32'h0, 4'hf);
		check("ctrl rw", rd, {16'h0, tit_pkg::TIT_CTRL_WMASK});
		bus(1'b1, 8'h00, 32'h0, 4'h1);
		bus(1'b0, 8'h00, 32'h0, 4'hf);
		check("lane", rd, 32'hff00);
		bus(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
		bus(1'b0, 8'h08, 32'h0, 4'hf);
		check("unmapped", rd, 32'h0);
	endtask
	// Role, PLL enable and reference selection
	task automatic t_pll();
		logic [3:0] cs [6] = '{4'h2, 4'h6, 4'h7, 4'h1, 4'hb, 4'hf};
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 8'h00, ctl({cs[i][0], cs[i][2:1], 6'h0}), 4'hf);
			osc <= cs[i][3];
			repeat (8) @(posedge clk_i);
			check("slave", slv, cs[i][2:1] != 2'b00);
			check("pll", pll, cs[i][0] && cs[i][3] && cs[i][2:1] != 0);
			for (int s = 0; s < 4; s++) begin
				ref_sel_i <= s[1:0];
				ref_i <= 4'h5 << i % 2;
				repeat (8) @(posedge clk_i);
				if (slv === 1'b1) begin
					check("ref", ck_o[5:4], pll ? {2{ref_i[s]}} : 2'b00);
					// Reference held still, so pulse 5 stays high
					check("ref fp", fp_o[5:4], 2'b11);
				end
			end
		end
	endtask
	// Frame detection over polarities and positions; the loop bit is ignored in slave role
	task automatic t_frames();
		logic [2:0] c;
		int n;
		src_en <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			c = i[2:0];
			s_pos <= c[2];
			s_ckp <= c[1];
			s_fpp <= c[0];
			bus(1'b1, 8'h00, ctl({3'b001, c[0], c[2] ^ (i == 8), c[1:0],
				2'b01}), 4'hf);
			repeat (200) @(posedge clk_i);
			bus(1'b1, 8'h04, 32'hc, 4'hf);
			// Source frame is exactly 100 cycles: three starts per window
			n = 0;
			repeat (300) begin
				@(posedge clk_i);
				if (fs === 1'b1)
					n++;
			end
			check("starts", n, (i != 8) ? 3 : 0);
			bus(1'b0, 8'h04, 32'h0, 4'hf);
			check("seen", rd[2], i != 8);
			if (i != 8)
				check("len", rd[27:16], 32'h8);
		end
	endtask
	// Pulse width limit per rate code
	task automatic t_rates();
		s_pos <= 1'b0;
		s_ckp <= 1'b0;
		s_fpp <= 1'b0;
		// 250 ns pulse: over the 122 and 244 ns limits, under 488 ns
		s_wide <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			bus(1'b1, 8'h00, ctl({7'b0010000, r[1:0]}), 4'hf);
			repeat (200) @(posedge clk_i);
			bus(1'b1, 8'h04, 32'hc, 4'hf);
			repeat (300) @(posedge clk_i);
			bus(1'b0, 8'h04, 32'h0, 4'hf);
			check("width err", rd[3], r < 2);
		end
		s_wide <= 1'b0;
	endtask
	// Master loopback: detector follows output clock 2 and pulse 2
	task automatic t_loop();
		// Pins stand still, rate code 00, starting pulse of the divider
		src_en <= 1'b0;
		bus(1'b1, 8'h00, ctl(9'b000110000), 4'hf);
		// Internal frame is 2048 clocks of 6 cycles each
		repeat (12400) @(posedge clk_i);
		bus(1'b1, 8'h04, 32'hc, 4'hf);
		repeat (12400) @(posedge clk_i);
		bus(1'b0, 8'h04, 32'h0, 4'hf);
		check("loop seen", rd[2], 1'b1);
		check("loop len", rd[27:16], 32'h800);
	endtask
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, osc, src_en} = 5'h0;
		{s_ckp, s_fpp, s_pos, s_wide} = 4'h0;
		wb_adr_i = 8'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		ref_i = 4'h0;
		ref_sel_i = 2'h0;
		repeat (3) @(posedge clk_i);
		// Outputs at their reset levels while reset still holds
		check("outs rst", {ck_o, pll, slv, fp_o}, 32'h3f);
		rst_i <= 1'b0;
		t_regs();
		t_pll();
		t_frames();
		t_rates();
		t_loop();
		give_verdict();
	end
endmodule
